// ### dac_input_mem.sv
// DAC input registers, one word per channel, registered read
`timescale 1ns/1ns
`default_nettype none
module dac_input_mem #(
    parameter int CHANNELS = 8,
    parameter int DAC_BITS = 12
) (
    // Clock
    input wire logic        ref_clk,
    // Ports
    dac_input_mem_if.store  mem
);
    logic [DAC_BITS-1:0] words [CHANNELS];

    always_ff @(posedge ref_clk) begin
        if (mem.wr_en) begin
            words[mem.wr_addr] <= mem.wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (mem.rd_en) begin
            mem.rd_data <= words[mem.rd_addr];
        end
    end
endmodule // dac_input_mem
`default_nettype wire

// ### dac_input_mem_if.sv
// Write and read port of the DAC input register store
`timescale 1ns/1ns
`default_nettype none
interface dac_input_mem_if #(
    parameter int CHANNELS = 8,
    parameter int DAC_BITS = 12
);
    logic                        wr_en;
    logic [$clog2(CHANNELS)-1:0] wr_addr;
    logic [DAC_BITS-1:0]         wr_data;
    logic                        rd_en;
    logic [$clog2(CHANNELS)-1:0] rd_addr;
    logic [DAC_BITS-1:0]         rd_data;

    modport user (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport store (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

// ### io_pin_config_dac_load_transfer_regs.sv
// Pin configuration registers and DAC load control
// Function
// - Pull-down bit 1 ties pin weakly to ground; 0 leaves other registers in charge.
// - Every pull-down enable bit resets to one and is host readable and writable.
// - Load mode field is bits 1:0, resets zero; bits 15:2 read-only.
// - Mode 00: input register write goes straight to DAC register and output.
// - Mode 01: writes only land in input registers; DAC outputs stay unchanged.
// - Writing mode 10 copies all input registers, then updates all outputs together.
// - Output-select bit n makes pin n a general-purpose output unless input-select bit n is also set.
// - Output data bit drives the output pin high when 1, low when 0.
// - Input-select bit n makes pin n a general-purpose input.
// - Select, data, input and load mode registers reset to zero.
// - Power-down and reference control register resets to zero, drives power-down and reference.
`timescale 1ns/1ns
`default_nettype none
`include "io_pin_config_defs.svh"
module io_pin_config_dac_load_transfer_regs #(
    parameter int CHANNELS = 8,
    parameter int DAC_BITS = 12
) (
    // Clock and reset
    input  wire logic                             ref_clk,
    input  wire logic                             reset_n,
    // Register port
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    input  wire logic [`REG_ADDR_W-1:0]           reg_addr,
    input  wire logic [`REG_DATA_W-1:0]           reg_wdata,
    output logic      [`REG_DATA_W-1:0]           reg_rdata,
    output logic                                  reg_rvalid,
    // DAC input register writes
    input  wire logic                             dac_wr,
    input  wire logic [$clog2(CHANNELS)-1:0]      dac_ch,
    input  wire logic [DAC_BITS-1:0]              dac_data,
    // DAC registers
    output logic      [CHANNELS-1:0][DAC_BITS-1:0] dac_value,
    output logic                                  dac_update,
    output logic                                  xfer_busy,
    // Pins
    input  wire logic [7:0]                       io_in,
    output logic      [7:0]                       io_out,
    output logic      [7:0]                       io_oe,
    output logic      [7:0]                       weak_sink_enable,
    // Power control
    output logic      [7:0]                       dac_powerdown,
    output logic                                  reference_enable,
    output logic                                  powerdown_all
);
    localparam int IDXW = $clog2(CHANNELS + 1);
    localparam int CHW  = $clog2(CHANNELS);
    localparam logic [IDXW-1:0] IDX_END = IDXW'(CHANNELS);
    localparam logic [CHW-1:0]  CH_LAST = CHW'(CHANNELS - 1);

    io_pin_config_pkg::dac_load_mode_t dac_load_mode;
    io_pin_config_pkg::xfer_state_t    xfer_state;
    logic [7:0]                        gp_output_select;
    logic [7:0]                        gp_output_data;
    logic [7:0]                        gp_input_select;
    logic [15:0]                       powerdown_reference_control;
    logic [7:0]                        gp_input_level;
    logic [IDXW-1:0]                   xfer_idx;
    logic                              rd_pending;
    logic [CHW-1:0]                    rd_idx;
    logic [CHANNELS-1:0][DAC_BITS-1:0] staging;
    logic                              start_xfer;

    dac_input_mem_if #(.CHANNELS(CHANNELS), .DAC_BITS(DAC_BITS)) mem ();

    dac_input_mem #(.CHANNELS(CHANNELS), .DAC_BITS(DAC_BITS)) u_store (
        .ref_clk (ref_clk),
        .mem     (mem)
    );

    function automatic logic hit(input logic [`REG_ADDR_W-1:0] a,
                                 input logic [`REG_ADDR_W-1:0] target);
        return a == target;
    endfunction

    assign start_xfer = reg_wr && hit(reg_addr, `ADDR_DAC_LOAD_MODE)
                        && (reg_wdata[1:0] == io_pin_config_pkg::LOAD_TRANSFER);
    assign mem.wr_en   = dac_wr;
    assign mem.wr_addr = dac_ch;
    assign mem.wr_data = dac_data;
    assign mem.rd_en   = (xfer_state == io_pin_config_pkg::XFER_COPY) && (xfer_idx != IDX_END);
    assign mem.rd_addr = xfer_idx[CHW-1:0];

    // Configuration writes; reserved bits are masked off
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            weak_sink_enable <= `RST_PULLDOWN;
            dac_load_mode    <= io_pin_config_pkg::LOAD_IMMEDIATE;
            gp_output_select <= `RST_PIN_FIELD;
            gp_output_data   <= `RST_PIN_FIELD;
            gp_input_select  <= `RST_PIN_FIELD;
            powerdown_reference_control <= `RST_PD_REF;
        end else if (reg_wr) begin
            if (hit(reg_addr, `ADDR_PIN_PULLDOWN)) begin
                weak_sink_enable <= reg_wdata[7:0];
            end
            if (hit(reg_addr, `ADDR_DAC_LOAD_MODE)) begin
                dac_load_mode <= io_pin_config_pkg::dac_load_mode_t'(reg_wdata[1:0]);
            end
            if (hit(reg_addr, `ADDR_GP_OUT_SELECT)) begin
                gp_output_select <= reg_wdata[7:0];
            end
            if (hit(reg_addr, `ADDR_GP_OUT_DATA)) begin
                gp_output_data <= reg_wdata[7:0];
            end
            if (hit(reg_addr, `ADDR_GP_IN_SELECT)) begin
                gp_input_select <= reg_wdata[7:0];
            end
            if (hit(reg_addr, `ADDR_POWERDOWN_REFERENCE_CONTROL)) begin
                powerdown_reference_control <= reg_wdata & `MASK_PD_REF;
            end
        end
    end

    // Register reads, answered one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                unique case (reg_addr)
                    `ADDR_PIN_PULLDOWN:  reg_rdata <= {8'h00, weak_sink_enable};
                    `ADDR_DAC_LOAD_MODE: reg_rdata <= {14'h0000, dac_load_mode};
                    `ADDR_GP_OUT_SELECT: reg_rdata <= {8'h00, gp_output_select};
                    `ADDR_GP_OUT_DATA:   reg_rdata <= {8'h00, gp_output_data};
                    `ADDR_GP_IN_SELECT:  reg_rdata <= {8'h00, gp_input_select};
                    `ADDR_POWERDOWN_REFERENCE_CONTROL:   reg_rdata <= powerdown_reference_control;
                    `ADDR_GP_IN_LEVEL:   reg_rdata <= {8'h00, gp_input_level};
                    default:             reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Pin drive and sampling; input selection takes precedence over output
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            io_oe          <= 8'h00;
            io_out         <= 8'h00;
            gp_input_level <= 8'h00;
        end else begin
            io_oe          <= gp_output_select & ~gp_input_select;
            io_out         <= gp_output_data;
            gp_input_level <= io_in & gp_input_select;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            dac_powerdown    <= 8'h00;
            reference_enable <= 1'b0;
            powerdown_all    <= 1'b0;
        end else begin
            dac_powerdown    <= powerdown_reference_control[7:0];
            reference_enable <= powerdown_reference_control[`REF_ENABLE_BIT];
            powerdown_all    <= powerdown_reference_control[`PD_ALL_BIT];
        end
    end

    // Bulk transfer: read each input register, then commit all at once
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            xfer_state <= io_pin_config_pkg::XFER_IDLE;
            xfer_idx   <= '0;
            rd_pending <= 1'b0;
            rd_idx     <= '0;
            xfer_busy  <= 1'b0;
        end else begin
            rd_pending <= mem.rd_en;
            rd_idx     <= xfer_idx[CHW-1:0];
            unique case (xfer_state)
                io_pin_config_pkg::XFER_IDLE: begin
                    if (start_xfer) begin
                        xfer_state <= io_pin_config_pkg::XFER_COPY;
                        xfer_idx   <= '0;
                        xfer_busy  <= 1'b1;
                    end
                end
                io_pin_config_pkg::XFER_COPY: begin
                    if (xfer_idx != IDX_END) begin
                        xfer_idx <= xfer_idx + IDXW'(1);
                    end
                    if (rd_pending && rd_idx == CH_LAST) begin
                        xfer_state <= io_pin_config_pkg::XFER_COMMIT;
                    end
                end
                io_pin_config_pkg::XFER_COMMIT: begin
                    xfer_state <= io_pin_config_pkg::XFER_IDLE;
                    xfer_busy  <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rd_pending) begin
            staging[rd_idx] <= mem.rd_data;
        end
    end

    // DAC registers; an immediate write after the commit in the same cycle wins
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            dac_value  <= '0;
            dac_update <= 1'b0;
        end else begin
            dac_update <= 1'b0;
            if (xfer_state == io_pin_config_pkg::XFER_COMMIT) begin
                dac_value  <= staging;
                dac_update <= 1'b1;
            end
            if (dac_wr && dac_load_mode == io_pin_config_pkg::LOAD_IMMEDIATE) begin
                dac_value[dac_ch] <= dac_data;
                dac_update        <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence load_mode_10_written;
        reg_wr && reg_addr == `ADDR_DAC_LOAD_MODE && reg_wdata[1:0] == 2'h2 && !xfer_busy;
    endsequence
    sequence commit_seen;
        ##10 (dac_update && !xfer_busy);
    endsequence

    immediate_load_a: assert property (
        dac_wr && dac_load_mode == io_pin_config_pkg::LOAD_IMMEDIATE
        |=> dac_update && dac_value[$past(dac_ch)] == $past(dac_data))
        else $error("immediate load did not reach the DAC register");
    hold_load_a: assert property (
        dac_load_mode == io_pin_config_pkg::LOAD_HOLD && !xfer_busy
        |=> $stable(dac_value) && !dac_update)
        else $error("DAC register changed while loads are held");
    transfer_commit_a: assert property (
        load_mode_10_written |=> xfer_busy [*1] ##0 commit_seen)
        else $error("bulk transfer did not commit eleven cycles after mode write");
    pulldown_reset_a: assert property (
        $rose(reset_n) |-> weak_sink_enable == 8'hFF && io_oe == 8'h00)
        else $error("pull-down enables not set out of reset");
    mode_write_a: assert property (
        reg_wr && reg_addr == `ADDR_DAC_LOAD_MODE
        |=> dac_load_mode == $past(reg_wdata[1:0]))
        else $error("load mode field did not take the written value");
    reserved_read_a: assert property (
        reg_rd && reg_addr == `ADDR_DAC_LOAD_MODE
        |=> reg_rvalid && reg_rdata[15:2] == 14'h0000)
        else $error("reserved load mode bits read nonzero");
    pin_drive_a: assert property (
        reg_wr && reg_addr == `ADDR_GP_OUT_SELECT && !gp_input_select[0]
        |=> ##1 io_oe[0] == $past(reg_wdata[0], 2))
        else $error("output enable does not follow output select");
    pin_level_a: assert property (
        reg_wr && reg_addr == `ADDR_GP_OUT_DATA |=> ##1 io_out == $past(reg_wdata[7:0], 2))
        else $error("output level does not follow output data");
    powerdown_a: assert property (
        reg_wr && reg_addr == `ADDR_POWERDOWN_REFERENCE_CONTROL
        |=> ##1 reference_enable == $past(reg_wdata[9], 2)
            && dac_powerdown == $past(reg_wdata[7:0], 2))
        else $error("power-down outputs do not follow control register");
endmodule // io_pin_config_dac_load_transfer_regs
`default_nettype wire

// ### io_pin_config_dac_load_transfer_regs_tb.sv
// Self-checking testbench of the pin configuration bank
`timescale 1ns/1ns
`default_nettype none
module io_pin_config_dac_load_transfer_regs_tb;
    logic              ref_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              reg_wr, reg_rd, reg_rvalid, dac_wr, dac_update, xfer_busy;
    logic [3:0]        reg_addr;
    logic [15:0]       reg_wdata, reg_rdata;
    logic [2:0]        dac_ch;
    logic [11:0]       dac_data;
    logic [7:0][11:0]  dac_value;
    logic [7:0]        io_in = 8'h00;
    logic [7:0]        io_out, io_oe, weak_sink_enable, dac_powerdown;
    logic              reference_enable, powerdown_all;
    int                tests_run = 0;
    int                fail_count = 0;

    always #50 ref_clk = ~ref_clk;

    io_pin_config_dac_load_transfer_regs io_pin_config_dac_load_transfer_regs_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .dac_wr(dac_wr), .dac_ch(dac_ch),
        .dac_data(dac_data), .dac_value(dac_value), .dac_update(dac_update),
        .xfer_busy(xfer_busy), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .weak_sink_enable(weak_sink_enable), .dac_powerdown(dac_powerdown),
        .reference_enable(reference_enable), .powerdown_all(powerdown_all));

    reg_host_model reg_host_model_i (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .dac_wr(dac_wr), .dac_ch(dac_ch), .dac_data(dac_data));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [3:0] addr, input logic [15:0] exp);
        logic [15:0] data;
        reg_host_model_i.read(addr, data);
        check(data, exp);
    endtask

    task automatic t_reset();
        rchk(4'h6, 16'h00FF);
        check({8'h00, weak_sink_enable}, 16'h00FF);
        rchk(4'h3, 16'h0000);
        rchk(4'h4, 16'h0000);
        rchk(4'h5, 16'h0000);
        rchk(4'h7, 16'h0000);
        rchk(4'hB, 16'h0000);
        rchk(4'h0, 16'h0000);
    endtask

    task automatic t_regs();
        for (int a = 3; a <= 6; a++) begin
            reg_host_model_i.write(a[3:0], 16'hFFFF);
            rchk(a[3:0], 16'h00FF);
        end
        reg_host_model_i.write(4'h7, 16'hFFFF);
        rchk(4'h7, 16'h0003);
        reg_host_model_i.write(4'h0, 16'h1234);
        rchk(4'h0, 16'h0000);
        reg_host_model_i.write(4'h6, 16'h0005);
        repeat (2) @(posedge ref_clk);
        check({8'h00, weak_sink_enable}, 16'h0005);
    endtask

    task automatic t_pins();
        reg_host_model_i.write(4'h3, 16'h000F);
        reg_host_model_i.write(4'h4, 16'h00A5);
        reg_host_model_i.write(4'h5, 16'h0003);
        io_in <= 8'h5B;
        repeat (3) @(posedge ref_clk);
        check({8'h00, io_oe}, 16'h000C);
        check({8'h00, io_out}, 16'h00A5);
        rchk(4'hC, 16'h0003);
    endtask

    task automatic t_immediate_hold();
        reg_host_model_i.write(4'h7, 16'h0000);
        reg_host_model_i.dac_write(3'h2, 12'hABC);
        @(posedge ref_clk);
        check({4'h0, dac_value[2]}, 16'h0ABC);
        check({15'h0000, dac_update}, 16'h0001);
        reg_host_model_i.write(4'h7, 16'h0001);
        for (int c = 0; c < 8; c++)
            reg_host_model_i.dac_write(c[2:0], 12'h100 + c[11:0]);
        @(posedge ref_clk);
        check({4'h0, dac_value[5]}, 16'h0000);
        check({4'h0, dac_value[2]}, 16'h0ABC);
        check({15'h0000, dac_update}, 16'h0000);
    endtask

    task automatic t_bulk();
        int pulses;
        int busy;
        pulses = 0;
        busy = 0;
        reg_host_model_i.write(4'h7, 16'h0002);
        repeat (15) begin
            @(posedge ref_clk);
            if (xfer_busy === 1'b1) busy++;
            if (dac_update === 1'b1) begin
                pulses++;
                check({4'h0, dac_value[0]}, 16'h0100);
                check({4'h0, dac_value[7]}, 16'h0107);
            end
        end
        check(pulses[15:0], 16'h0001);
        check({15'h0000, busy > 0}, 16'h0001);
        for (int c = 1; c < 7; c++)
            check({4'h0, dac_value[c]}, 16'h0100 + c[15:0]);
        rchk(4'h7, 16'h0002);
    endtask

    task automatic t_power();
        reg_host_model_i.write(4'hB, 16'hFFFF);
        rchk(4'hB, 16'h06FF);
        repeat (2) @(posedge ref_clk);
        check({6'h00, powerdown_all, reference_enable, dac_powerdown}, 16'h03FF);
    endtask

    task automatic final_report();
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_regs();
        t_pins();
        t_immediate_hold();
        t_bulk();
        t_power();
        final_report();
    end

    // Whole run needs about 125 cycles
    initial begin
        #(5000 * 100);
        fail_count++;
        final_report();
    end
endmodule // io_pin_config_dac_load_transfer_regs_tb
`default_nettype wire

// ### io_pin_config_defs.svh
// Register pointers, field masks, reset values and widths of the pin configuration bank
`ifndef IO_PIN_CONFIG_DEFS_SVH
`define IO_PIN_CONFIG_DEFS_SVH

`define REG_ADDR_W          4
`define REG_DATA_W          16

`define ADDR_PIN_PULLDOWN   4'h6
`define ADDR_DAC_LOAD_MODE  4'h7
`define ADDR_GP_OUT_SELECT  4'h3
`define ADDR_GP_OUT_DATA    4'h4
`define ADDR_GP_IN_SELECT   4'h5
`define ADDR_POWERDOWN_REFERENCE_CONTROL    4'hB
`define ADDR_GP_IN_LEVEL    4'hC

`define MASK_PIN_FIELD      16'h00FF
`define MASK_LOAD_MODE      16'h0003
`define MASK_PD_REF         16'h06FF

`define RST_PULLDOWN        8'hFF
`define RST_PIN_FIELD       8'h00
`define RST_PD_REF          16'h0000

`define LOAD_MODE_LSB       0
`define PD_ALL_BIT          10
`define REF_ENABLE_BIT      9

`endif

// ### io_pin_config_pkg.sv
// Types shared by the pin configuration bank
package io_pin_config_pkg;

    typedef enum logic [1:0] {
        LOAD_IMMEDIATE = 2'h0,
        LOAD_HOLD      = 2'h1,
        LOAD_TRANSFER  = 2'h2,
        LOAD_SPARE     = 2'h3
    } dac_load_mode_t;

    typedef enum logic [2:0] {
        XFER_IDLE   = 3'h1,
        XFER_COPY   = 3'h2,
        XFER_COMMIT = 3'h4
    } xfer_state_t;

endpackage

// ### reg_host_model.sv
// Host model that issues register accesses and DAC input writes
`timescale 1ns/1ns
`default_nettype none
`include "io_pin_config_defs.svh"
module reg_host_model #(
    parameter int CHANNELS = 8,
    parameter int DAC_BITS = 12
) (
    // Clock
    input  wire logic                        ref_clk,
    // Register port
    output logic                             reg_wr,
    output logic                             reg_rd,
    output logic [`REG_ADDR_W-1:0]           reg_addr,
    output logic [`REG_DATA_W-1:0]           reg_wdata,
    input  wire logic [`REG_DATA_W-1:0]      reg_rdata,
    input  wire logic                        reg_rvalid,
    // DAC input writes
    output logic                             dac_wr,
    output logic [$clog2(CHANNELS)-1:0]      dac_ch,
    output logic [DAC_BITS-1:0]              dac_data
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 16'h0000;
        dac_wr    = 1'b0;
        dac_ch    = '0;
        dac_data  = '0;
    end

    task automatic write(input logic [3:0] addr, input logic [15:0] data);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~data;
    endtask

    // Data is unknown when no valid pulse follows the request
    task automatic read(input logic [3:0] addr, output logic [15:0] data);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(posedge ref_clk);
        data = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
    endtask

    task automatic dac_write(input logic [2:0] ch, input logic [11:0] data);
        @(posedge ref_clk);
        dac_wr   <= 1'b1;
        dac_ch   <= ch;
        dac_data <= data;
        @(posedge ref_clk);
        dac_wr   <= 1'b0;
        dac_data <= ~data;
    endtask
endmodule // reg_host_model
`default_nettype wire
